// *** rtl/smr_pkg.sv ***
// package of constants and types for the sbc spi register map and mode control
package smr_pkg;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int FRAME_BITS   = 16;
  localparam int HDR_BITS     = 4;
  localparam int DATA_BITS    = 12;
  localparam int ADDR_HI      = 15;
  localparam int ADDR_LO      = 14;
  localparam int FBSEL_POS    = 13;
  localparam int RO_POS       = 12;
  localparam int WDP_HI       = 11;
  localparam int WDP_LO       = 6;
  localparam int OM_HI        = 5;
  localparam int OM_LO        = 3;
  localparam int SDM_POS      = 2;
  localparam int EN_POS       = 1;

  // ****************************************************************
  // register slots and reset values
  // ****************************************************************
  localparam logic [1:0]  ADDR_MODE   = 2'h0;
  localparam logic [1:0]  ADDR_INTEN  = 2'h1;
  localparam logic [1:0]  ADDR_CFG    = 2'h2;
  localparam logic [1:0]  ADDR_PHY    = 2'h3;
  localparam logic [11:0] DATA_RST    = 12'h000;
  localparam logic [5:0]  WDP_RST     = 6'h09;
  localparam logic [3:0]  RSS_NONE    = 4'h0;
  localparam logic [3:0]  RSS_FLASH   = 4'h1;
  localparam logic [3:0]  RSS_ILLEGAL = 4'h2;
  localparam logic [3:0]  RSS_CLKCNT  = 4'h3;
  localparam logic [4:0]  CNT16       = 5'h10;

  // ****************************************************************
  // operating mode codes
  // ****************************************************************
  localparam logic [2:0] OM_NORMAL     = 3'h1;
  localparam logic [2:0] OM_STANDBY    = 3'h2;
  localparam logic [2:0] OM_INIT_FLASH = 3'h3;
  localparam logic [2:0] OM_SLEEP      = 3'h4;
  localparam logic [2:0] OM_INIT_NORM  = 3'h5;
  localparam logic [2:0] OM_LEAVE_FL   = 3'h6;
  localparam logic [2:0] OM_FLASH      = 3'h7;

  typedef enum logic [5:0] {
    SMR_STARTUP = 6'b000001,
    SMR_RESTART = 6'b000010,
    SMR_NORMAL  = 6'b000100,
    SMR_STANDBY = 6'b001000,
    SMR_FLASH   = 6'b010000,
    SMR_SLEEP   = 6'b100000
  } smr_mode_e;

  // decoded frame carried from link to core
  typedef struct packed {
    logic [1:0]  addr;
    logic        fbsel;
    logic        ro;
    logic [11:0] data;
  } smr_frame_s;

  // read-back words supplied by the rest of the chip
  typedef struct packed {
    logic [11:0] sys_status;
    logic [11:0] sys_diag;
    logic [11:0] int_flags;
    logic [11:0] special_fb;
    logic [11:0] gp0_fb;
    logic [11:0] gp1_fb;
  } smr_fb_s;

endpackage : smr_pkg

// *** rtl/smr_core.sv ***
// spi register access and mode/watchdog control of the system basis chip
`timescale 1ns/10ps

// Function
// R1: frame is 4 header plus 12 data
// R2: bits 15..14 select register slot
// R3: bit 13 picks one of two feedbacks
// R4: bit 12 set means read without write
// R5: slot 00 writes mode, reads status/diagnosis
// R6: slot 01 interrupt enable or special mode
// R7: slot 10 configuration or general purpose 0
// R8: slot 11 physical layer or general purpose 1
// R9: every writable control bit reads back; here only the interrupt enable, configuration and physical layer words do
// R10: mode change only with watchdog service
// R11: mode register writable in every mode
// R12: master writes mode early after reset
// R13: illegal codes discarded, force system reset
// R14: mode field decode, 000 illegal
// R15: bit 2 enables software development mode
// R16: bit 1 drives enable pin level
// R17: master keeps bit 0 zero
// R18: normal flash normal flash forces reset
// R19: reset source shows flash entry
// R20: init flash after that reset enters flash
// R21: exactly 16 clocks, else ignore and flag; in startup and restart the code forces a reset with source RSS_CLKCNT instead
// R22: sample falling edge, shift rising edge
// R23: feedback shifted out during frame
// R24: watchdog period code goes to timer
// R25: frames shift most significant bit first
// R26: output floats unselected, write at end
module smr_core (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            sck,
  input  wire logic            chip_select_n,
  input  wire logic            serial_in,
  output logic                 serial_out,
  output logic                 serial_out_oe,
  input  wire smr_pkg::smr_fb_s fb_in,
  output logic                 enable_pin,
  output logic                 sw_dev_mode,
  output logic [5:0]           watchdog_period_code,
  output logic                 wd_service,
  output logic                 sys_reset_req,
  output logic                 spi_fail_int,
  output logic [3:0]           reset_source_bits,
  output logic [2:0]           op_mode
);
  import smr_pkg::*;

  // ****************************************************************
  // link domain: shift register on the spi clock
  // ****************************************************************
  logic [15:0] sh_r;
  logic [4:0]  cnt_r;
  logic [15:0] tx_r;
  logic [11:0] fbword;
  logic        flip_r;
  smr_frame_s  cap_r;
  logic        capok_r;

  // falling edge samples; chip select restarts the count
  always_ff @(negedge sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      cnt_r <= 5'h00;
      sh_r  <= 16'h0000;
    end else begin
      sh_r  <= {sh_r[14:0], serial_in};                   // R22 R25
      cnt_r <= (cnt_r == 5'h1F) ? cnt_r : cnt_r + 5'h01;
    end
  end

  // rising edge shifts; word chosen once slot and select are in, so the
  // fourth header bit echoes the select and data bits 11..0 carry the word
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      tx_r <= 16'h0000;
    end else if (cnt_r == 5'h03) begin
      tx_r <= {sh_r[0], fbword, 3'h0};                   // R23
    end else begin
      tx_r <= {tx_r[14:0], 1'b0};
    end
  end

  // frame end: capture on chip select rise, count must be exactly 16
  always_ff @(posedge chip_select_n or negedge rst_n) begin
    if (!rst_n) begin
      cap_r   <= '0;
      capok_r <= 1'b0;
      flip_r  <= 1'b0;
    end else begin
      cap_r   <= smr_frame_s'(sh_r);                      // R1 R2 R3 R4
      capok_r <= (cnt_r == CNT16);                        // R21
      flip_r  <= ~flip_r;
    end
  end

  // ****************************************************************
  // crossing into the system clock domain
  // ****************************************************************
  logic [2:0] tgl_sync_r;
  logic       frame_evt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_sync_r <= 3'h0;
    end else begin
      tgl_sync_r <= {tgl_sync_r[1:0], flip_r};
    end
  end
  // frame words change with the toggle and are stable for two clk cycles before it lands
  assign frame_evt = tgl_sync_r[2] ^ tgl_sync_r[1];

  // ****************************************************************
  // mode state and mode register
  // ****************************************************************
  smr_mode_e   mode_r, mode_nxt;
  logic [11:0] mreg_r, mreg_nxt;
  logic [11:0] inten_r, inten_nxt, spec_r, spec_nxt, cfg_r, cfg_nxt;
  logic [11:0] phy_r, phy_nxt, gp0_r, gp0_nxt, gp1_r, gp1_nxt;
  logic [1:0]  seq_r, seq_nxt;
  logic [3:0]  rss_r, rss_nxt;
  logic        rst_req_r, rst_req_nxt, fail_r, fail_nxt, svc_r, svc_nxt;

  function automatic logic legal_wdp(input logic [5:0] c);
    case (c)
      6'h09, 6'h0C, 6'h12, 6'h14, 6'h1B,
      6'h24, 6'h2D, 6'h33, 6'h35, 6'h36: legal_wdp = 1'b1;
      default:                           legal_wdp = 1'b0;
    endcase
  endfunction : legal_wdp

  function automatic logic is_boot(input smr_mode_e m);
    is_boot = (m == SMR_STARTUP) || (m == SMR_RESTART);
  endfunction : is_boot

  // feedback selection for the frame under way
  always_comb begin
    case ({sh_r[2:1], sh_r[0]})
      3'b000:  fbword = fb_in.sys_status;
      3'b001:  fbword = fb_in.sys_diag;
      3'b010:  fbword = inten_r;                          // R6 R9
      3'b011:  fbword = is_boot(mode_r) ? fb_in.special_fb : fb_in.int_flags;
      3'b100:  fbword = cfg_r;                            // R7 R9
      3'b101:  fbword = fb_in.gp0_fb;
      3'b110:  fbword = phy_r;                            // R8 R9
      default: fbword = fb_in.gp1_fb;
    endcase
  end

  logic [2:0] om;
  logic       wr;
  always_comb begin
    mode_nxt = mode_r;
    mreg_nxt = mreg_r;
    inten_nxt = inten_r;
    spec_nxt = spec_r;
    cfg_nxt = cfg_r;
    phy_nxt = phy_r;
    gp0_nxt = gp0_r;
    gp1_nxt = gp1_r;
    seq_nxt = seq_r;
    rss_nxt = rss_r;
    rst_req_nxt = 1'b0;
    fail_nxt = 1'b0;
    svc_nxt = 1'b0;
    om = cap_r.data[OM_HI:OM_LO];
    wr = frame_evt && capok_r && !cap_r.ro;               // R4 R26
    if (frame_evt && !capok_r) begin
      if (is_boot(mode_r)) begin                          // R21
        rst_req_nxt = 1'b1;
        rss_nxt = RSS_CLKCNT;
        mode_nxt = SMR_RESTART;
      end else begin
        fail_nxt = 1'b1;
      end
    end else if (wr) begin
      case (cap_r.addr)
        ADDR_MODE: begin                                  // R5 R11
          if (!legal_wdp(cap_r.data[WDP_HI:WDP_LO]) || om == 3'h0) begin
            rst_req_nxt = 1'b1;                           // R13 R14
            rss_nxt = RSS_ILLEGAL;
            mode_nxt = SMR_RESTART;
            seq_nxt = 2'h0;
          end else begin
            mreg_nxt = cap_r.data;                        // R10 R15 R16
            svc_nxt = 1'b1;
            // flash entry: normal, flash, normal, flash
            if (om == OM_FLASH && seq_r == 2'h3) begin    // R18 R19
              rst_req_nxt = 1'b1;
              rss_nxt = RSS_FLASH;
              mode_nxt = SMR_STARTUP;
              seq_nxt = 2'h0;
            end else if (om == OM_NORMAL) begin
              seq_nxt = (seq_r == 2'h2) ? 2'h2 : 2'h1;
              seq_nxt = (seq_r == 2'h2) ? 2'h3 : seq_nxt;
              if (mode_r == SMR_STANDBY || mode_r == SMR_FLASH || is_boot(mode_r)) begin
                mode_nxt = SMR_NORMAL;
              end
            end else if (om == OM_FLASH) begin
              seq_nxt = (seq_r == 2'h1) ? 2'h2 : 2'h0;
            end else begin
              seq_nxt = 2'h0;
              case (om)
                OM_STANDBY:    mode_nxt = SMR_STANDBY;
                OM_SLEEP:      mode_nxt = SMR_SLEEP;
                OM_INIT_NORM:  mode_nxt = SMR_NORMAL;
                OM_LEAVE_FL:   mode_nxt = SMR_NORMAL;
                OM_INIT_FLASH: begin                      // R20
                  if (mode_r == SMR_STARTUP && rss_r == RSS_FLASH) begin
                    mode_nxt = SMR_FLASH;
                  end
                end
                default: mode_nxt = mode_r;
              endcase
            end
          end
        end
        ADDR_INTEN: begin
          if (is_boot(mode_r)) spec_nxt = cap_r.data;     // R6
          else inten_nxt = cap_r.data;
        end
        ADDR_CFG: begin
          if (mode_r == SMR_NORMAL || mode_r == SMR_STANDBY) cfg_nxt = cap_r.data;  // R7
          else gp0_nxt = cap_r.data;
        end
        default: begin
          if (mode_r == SMR_NORMAL || mode_r == SMR_STANDBY) phy_nxt = cap_r.data;  // R8
          else gp1_nxt = cap_r.data;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= SMR_STARTUP;
      mreg_r <= {WDP_RST, 6'h00};
      inten_r <= DATA_RST;
      spec_r <= DATA_RST;
      cfg_r <= DATA_RST;
      phy_r <= DATA_RST;
      gp0_r <= DATA_RST;
      gp1_r <= DATA_RST;
      seq_r <= 2'h0;
      rss_r <= RSS_NONE;
      rst_req_r <= 1'b0;
      fail_r <= 1'b0;
      svc_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      mreg_r <= mreg_nxt;
      inten_r <= inten_nxt;
      spec_r <= spec_nxt;
      cfg_r <= cfg_nxt;
      phy_r <= phy_nxt;
      gp0_r <= gp0_nxt;
      gp1_r <= gp1_nxt;
      seq_r <= seq_nxt;
      rss_r <= rss_nxt;
      rst_req_r <= rst_req_nxt;
      fail_r <= fail_nxt;
      svc_r <= svc_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(negedge sck or posedge chip_select_n) begin
    if (chip_select_n) serial_out_oe <= 1'b0;             // R26
    else serial_out_oe <= 1'b1;
  end
  assign serial_out = tx_r[15];
  assign enable_pin = mreg_r[EN_POS];                     // R16
  assign sw_dev_mode = mreg_r[SDM_POS];                   // R15
  assign watchdog_period_code = mreg_r[WDP_HI:WDP_LO];    // R24
  assign wd_service = svc_r;
  assign sys_reset_req = rst_req_r;
  assign spi_fail_int = fail_r;
  assign reset_source_bits = rss_r;
  assign op_mode = mreg_r[OM_HI:OM_LO];

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_illegal_reset: assert property (@(posedge clk) disable iff (!rst_n)  // R13
    (wr && cap_r.addr == ADDR_MODE && om == 3'h0) |=> sys_reset_req && $stable(enable_pin))
    else $error("illegal mode code did not force reset");
  chk_bad_period: assert property (@(posedge clk) disable iff (!rst_n)  // R13
    (wr && cap_r.addr == ADDR_MODE && !legal_wdp(cap_r.data[WDP_HI:WDP_LO]))
      |=> sys_reset_req && reset_source_bits == RSS_ILLEGAL && $stable(watchdog_period_code))
    else $error("illegal watchdog period not refused");
  chk_ro_nowrite: assert property (@(posedge clk) disable iff (!rst_n)  // R4
    (frame_evt && cap_r.ro) |=> $stable(mreg_r) && $stable(cfg_r))
    else $error("read-only frame changed a register");
  chk_count_fail: assert property (@(posedge clk) disable iff (!rst_n)  // R21
    (frame_evt && !capok_r && !is_boot(mode_r)) |=> spi_fail_int && $stable(mreg_r))
    else $error("bad clock count not flagged");
  chk_flash_src: assert property (@(posedge clk) disable iff (!rst_n)  // R19
    (rst_req_nxt && rss_nxt == RSS_FLASH) |=> reset_source_bits == RSS_FLASH
      && mode_r == SMR_STARTUP)
    else $error("flash entry reset source wrong");
  // mode and service flops load on the same edge, so the pulse stands now
  chk_service_mode: assert property (@(posedge clk) disable iff (!rst_n)  // R10
    ($changed(mode_r) && !sys_reset_req) |-> wd_service)
    else $error("mode changed without watchdog service");
endmodule : smr_core

// *** bench/smr_spi_master.sv ***
// spi master model standing in for the microcontroller
`timescale 1ns/10ps

module smr_spi_master (
  output logic      sck,
  output logic      chip_select_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  // ****************************************************************
  // frame driver, clock stands low outside frames
  // ****************************************************************
  initial begin
    sck           = 1'b0;
    chip_select_n = 1'b1;
    serial_in     = 1'b0;
  end

  // nclk other than 16 only when a count fault is wanted
  task automatic xfer(input logic [15:0] tx, input int nclk, output logic [15:0] rx);
    rx = 16'h0000;
    chip_select_n = 1'b0;
    serial_in = tx[15];
    #40;
    for (int i = 0; i < nclk; i++) begin
      sck = 1'b1;
      serial_in = (i < 16) ? tx[15-i] : 1'b0;
      #40;
      sck = 1'b0;
      rx = {rx[14:0], serial_out};
      #40;
    end
    chip_select_n = 1'b1;
    // released line must not look like held data
    serial_in = ~serial_in;
  endtask : xfer
endmodule : smr_spi_master

// *** bench/sbc_spi_register_map_mode_ctrl_tb.sv ***
// self-checking bench for the spi register map and mode control
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end

module sbc_spi_register_map_mode_ctrl_tb;
  import smr_pkg::*;
  logic        clk, rst_n, sck, chip_select_n, serial_in, serial_out, serial_out_oe, sdo_w;
  logic        enable_pin, sw_dev_mode, wd_service, sys_reset_req, spi_fail_int;
  logic [5:0]  watchdog_period_code;
  logic [3:0]  reset_source_bits;
  logic [2:0]  op_mode;
  logic [15:0] rx;
  logic [95:0] rnd;
  smr_fb_s     fb_in;
  int          errors, tests_run, cycles, seed, n_svc, n_rst, n_fail, e_svc, e_rst, e_fail;
  logic        e_en, e_sdm, chk_svc;
  logic [5:0]  e_wdp;
  logic [11:0] e_wr;
  logic [5:0]  wdp_tab [10] = '{6'h09, 6'h0C, 6'h12, 6'h14, 6'h1B,
                                6'h24, 6'h2D, 6'h33, 6'h35, 6'h36};

  assign sdo_w = serial_out_oe ? serial_out : 1'bz;

  smr_core dut (.clk(clk), .rst_n(rst_n), .sck(sck), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .fb_in(fb_in), .enable_pin(enable_pin), .sw_dev_mode(sw_dev_mode),
    .watchdog_period_code(watchdog_period_code), .wd_service(wd_service),
    .sys_reset_req(sys_reset_req), .spi_fail_int(spi_fail_int),
    .reset_source_bits(reset_source_bits), .op_mode(op_mode));

  smr_spi_master m (.sck(sck), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .serial_out(sdo_w));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (wd_service === 1'b1) n_svc++;
    if (sys_reset_req === 1'b1) n_rst++;
    if (spi_fail_int === 1'b1) n_fail++;
    if (cycles == 20000) begin
      errors++;
      print_verdict;
    end
  end

  task print_verdict;
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // transfers and model comparisons
  // ****************************************************************
  task automatic frame(input logic [1:0] a, input logic s, r, input logic [11:0] d,
                       input int n);
    @(negedge clk);
    m.xfer({a, s, r, d}, n, rx);
    repeat (12) @(negedge clk);
    `CHK(serial_out_oe, 1'b0)
    `CHK(n_rst, e_rst)
    `CHK(n_fail, e_fail)
  endtask : frame

  task automatic state;
    `CHK(enable_pin, e_en)
    `CHK(sw_dev_mode, e_sdm)
    `CHK(watchdog_period_code, e_wdp)
    if (chk_svc) `CHK(n_svc, e_svc)
  endtask : state

  task automatic wr_mode(input logic [2:0] om, input logic ro);
    logic [11:0] d;
    d[11:6] = wdp_tab[$unsigned($random(seed)) % 10];
    d[5:3] = om;
    d[2:1] = 2'($random(seed));
    d[0] = 1'b0;
    frame(ADDR_MODE, 1'b0, ro, d, 16);
    if (!ro) begin
      e_wdp = d[11:6];
      e_sdm = d[2];
      e_en = d[1];
      e_svc++;
    end
  endtask : wr_mode

  // slot 1 select 1 word depends on mode; read only so nothing may change
  task automatic rd_all(input logic nrm);
    logic [11:0] ev;
    logic [1:0]  a;
    for (int k = 0; k < 5; k++) begin
      rnd = {$random(seed), $random(seed), $random(seed)};
      fb_in = rnd[71:0];
      a = (k < 2) ? 2'h0 : 2'(k - 1);
      case (k)
        0: ev = fb_in.sys_status;
        1: ev = fb_in.sys_diag;
        2: ev = nrm ? fb_in.int_flags : fb_in.special_fb;
        3: ev = fb_in.gp0_fb;
        default: ev = fb_in.gp1_fb;
      endcase
      frame(a, k != 0, 1'b1, 12'($random(seed)), 16);
      `CHK(rx[11:0], ev)
    end
    state();
  endtask : rd_all

  initial begin
    seed = 37;
    rst_n = 1'b0;
    fb_in = '0;
    chk_svc = 1'b1;
    {e_en, e_sdm} = 2'b00;
    e_wdp = WDP_RST;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    state();
    `CHK(reset_source_bits, RSS_NONE)
    e_rst++;
    frame(ADDR_MODE, 1'b0, 1'b0, {WDP_RST, 3'h0, 3'h6}, 16);
    `CHK(reset_source_bits, RSS_ILLEGAL)
    e_rst++;
    frame(ADDR_MODE, 1'b0, 1'b0, {6'h01, OM_NORMAL, 3'h6}, 16);
    state();
    for (int n = 15; n < 18; n += 2) begin
      e_rst++;
      frame(ADDR_PHY, 1'b0, 1'b0, 12'hFFE, n);
      `CHK(reset_source_bits, RSS_CLKCNT)
    end
    state();
    rd_all(1'b0);
    repeat (4) begin
      wr_mode(OM_NORMAL, 1'b0);
      state();
    end
    `CHK(op_mode, OM_NORMAL)
    // normal mode: slots 1..3 write the control words that select 0 reads back
    for (int k = 1; k < 4; k++) begin
      e_wr = 12'($random(seed));
      frame(2'(k), 1'b0, 1'b0, e_wr, 16);
      frame(2'(k), 1'b0, 1'b1, 12'h000, 16);
      `CHK(rx[11:0], e_wr)
    end
    wr_mode(OM_STANDBY, 1'b1);
    state();
    rd_all(1'b1);
    e_fail++;
    frame(ADDR_MODE, 1'b0, 1'b0, 12'h04A, 15);
    state();
    wr_mode(OM_NORMAL, 1'b0);
    wr_mode(OM_FLASH, 1'b0);
    wr_mode(OM_NORMAL, 1'b0);
    state();
    chk_svc = 1'b0;
    e_rst++;
    wr_mode(OM_FLASH, 1'b0);
    `CHK(reset_source_bits, RSS_FLASH)
    wr_mode(OM_INIT_FLASH, 1'b0);
    state();
    `CHK(op_mode, OM_INIT_FLASH)
    // flash mode is no boot mode: slot 1 select 1 must give the interrupt word
    rd_all(1'b1);
    print_verdict;
  end
endmodule : sbc_spi_register_map_mode_ctrl_tb
